// File: design/tpbs_pkg.sv
// Package of constants and types for the boot strap sequencer, plus the strap pin synchroniser.
// How it works
// - Power-on reset sets the first-boot flag.
// - Entry code reads only the first-boot flag.
// - Secure registers answer only during device-init.
// - First boot runs device-init code before user code.
// - Ending first boot clears flag, changes master identifier.
// - Processor then resets itself into second boot.
// - Second boot sees flag cleared, new master identifier.
// - Outside serial load, second boot hands over to application code.
// - Secure region stays locked until power cycle.
// - Three strap bits are sampled at power-up.
// - Strap bits latched before processor reset release.
// - Strap value selects boot flow and pin mapping.
// - Top bit alone high selects serial load.
// - Serial load waits for code without timeout.
// - Serial load forces four-wire debug until repowered.
// - Lowest bit alone high selects two-wire debug.
// - All bits low select four-wire debug.
package tpbs_pkg;

    localparam int          CLK_PERIOD_PS      = 5000;
    localparam int          STRAP_SETTLE_NS    = 40;
    localparam int          STRAP_SETTLE_CYC   = (STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          SELF_RESET_NS      = 100;
    localparam int          SELF_RESET_CYC     = (SELF_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam logic [11:0] STATUS_OFFSET      = 12'h000;
    localparam logic [11:0] CTRL_OFFSET        = 12'h004;
    localparam logic [11:0] SECURE_OFFSET      = 12'h008;

    localparam int          CTRL_INIT_DONE_BIT = 0;
    localparam int          CTRL_SELF_RST_BIT  = 1;
    localparam int          CTRL_ROM_DONE_BIT  = 2;

    localparam logic [2:0]  SERIAL_LOAD_STRAP_SETTING = 3'h4;
    localparam logic [2:0]  TWO_WIRE_STRAP_SETTING    = 3'h1;
    localparam logic [2:0]  FOUR_WIRE_STRAP_SETTING   = 3'h0;

    localparam logic [3:0]  MASTER_ID_INIT     = 4'h1;
    localparam logic [3:0]  MASTER_ID_MCU      = 4'h2;
    localparam logic [31:0] SECURE_RESET       = 32'h0000_0000;

    typedef enum logic [1:0] {
        MODE_FOUR_WIRE   = 2'h0,
        MODE_TWO_WIRE    = 2'h1,
        MODE_SERIAL_LOAD = 2'h2,
        MODE_UNDEFINED   = 2'h3
    } tpbs_mode_type;

    typedef struct packed {
        logic [13:0]   reserved;
        logic          app_running;
        logic          self_reset_busy;
        logic          secure_open;
        logic [2:0]    phase;
        logic [2:0]    power_up_strap;
        tpbs_mode_type mode;
        logic [3:0]    master_id;
        logic [1:0]    unused;
        logic          first_boot;
    } tpbs_status_type;

endpackage

////////////////////////////////////////////////////////////////////////////////

`timescale 1ns/1ps
`default_nettype none

module tpbs_strap_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] value_out,
    output var  logic             change_out
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] value_next;
    logic             change_next;

    // A new value counts once the second and third stages agree.
    always_comb begin
        value_next  = value_out;
        change_next = 1'b0;
        if (s2_reg == s3_reg && s3_reg != value_out) begin
            value_next  = s3_reg;
            change_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg     <= '0;
            s2_reg     <= '0;
            s3_reg     <= '0;
            value_out  <= '0;
            change_out <= 1'b1;
        end else begin
            s1_reg     <= pin_in;
            s2_reg     <= s1_reg;
            s3_reg     <= s2_reg;
            value_out  <= value_next;
            change_out <= change_next;
        end
    end

endmodule

`default_nettype wire

// File: design/tpbs_sequencer.sv
// Two-phase boot sequencer with strap capture and an APB register slave.
`timescale 1ns/1ps
`default_nettype none

module tpbs_sequencer #(
    parameter logic [3:0] INIT_MASTER_ID = tpbs_pkg::MASTER_ID_INIT,
    parameter logic [3:0] MCU_MASTER_ID  = tpbs_pkg::MASTER_ID_MCU
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RESETN,
    input  wire logic [2:0]  POWER_UP_STRAP,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    output var  logic        CPU_RESETN,
    output var  logic        FIRST_BOOT,
    output var  logic        DEVICE_INIT_RUN,
    output var  logic        APP_JUMP,
    output var  logic        SECURE_OPEN,
    output var  logic [3:0]  MASTER_ID,
    output var  logic [1:0]  BOOT_MODE,
    output var  logic        SERIAL_LOAD_MODE,
    output var  logic        FUNC_FOUR_WIRE_DEBUG,
    output var  logic        FUNC_TWO_WIRE_DEBUG
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    typedef enum logic [2:0] {
        ST_CAPTURE,
        ST_INIT_BOOT,
        ST_SELF_RESET,
        ST_MCU_BOOT,
        ST_APP
    } tpbs_state_type;

    tpbs_state_type          state_reg;
    tpbs_state_type          state_next;
    logic [7:0]              count_reg;
    logic [7:0]              count_next;
    logic                    first_boot_reg;
    logic                    first_boot_next;
    logic                    init_done_reg;
    logic                    init_done_next;
    logic [3:0]              master_id_reg;
    logic [3:0]              master_id_next;
    logic [2:0]              strap_reg;
    logic [2:0]              strap_next;
    logic [31:0]             secure_reg;
    logic [31:0]             secure_next;
    logic [31:0]             prdata_reg;
    logic [31:0]             prdata_next;
    logic                    pready_reg;
    logic                    pready_next;
    logic                    pslverr_reg;
    logic                    pslverr_next;
    logic [2:0]              strap_sync;
    logic                    strap_change;
    logic                    secure_ok;
    logic                    wr_fire;
    tpbs_pkg::tpbs_mode_type mode;
    tpbs_pkg::tpbs_status_type status;

    ////////////////////////////////////////////////////////////////////////////////
    // Strap pin synchroniser.

    tpbs_strap_sync #(
        .WIDTH      (3)
    ) u_strap_sync (
        .clk        (CORE_CLK),
        .rst_n      (RESETN),
        .pin_in     (POWER_UP_STRAP),
        .value_out  (strap_sync),
        .change_out (strap_change)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Strap decode.

    always_comb begin
        unique case (strap_reg)
            tpbs_pkg::SERIAL_LOAD_STRAP_SETTING: mode = tpbs_pkg::MODE_SERIAL_LOAD;
            tpbs_pkg::TWO_WIRE_STRAP_SETTING:    mode = tpbs_pkg::MODE_TWO_WIRE;
            tpbs_pkg::FOUR_WIRE_STRAP_SETTING:   mode = tpbs_pkg::MODE_FOUR_WIRE;
            default:                             mode = tpbs_pkg::MODE_UNDEFINED;
        endcase
    end

    // Secure access needs the device-init phase of the first boot only.
    assign secure_ok = (state_reg == ST_INIT_BOOT) && first_boot_reg;
    assign wr_fire   = PSEL && PENABLE && pready_reg && PWRITE && !pslverr_reg;

    always_comb begin
        status                 = '0;
        status.first_boot      = first_boot_reg;
        status.master_id       = master_id_reg;
        status.mode            = mode;
        status.power_up_strap  = strap_reg;
        status.phase           = state_reg;
        status.secure_open     = secure_ok;
        status.self_reset_busy = (state_reg == ST_SELF_RESET);
        status.app_running     = (state_reg == ST_APP);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Boot sequence.

    always_comb begin
        state_next      = state_reg;
        count_next      = count_reg;
        first_boot_next = first_boot_reg;
        init_done_next  = init_done_reg;
        master_id_next  = master_id_reg;
        strap_next      = strap_reg;
        secure_next     = secure_reg;
        unique case (state_reg)
            ST_CAPTURE: begin
                // Strap is copied while the processor is still held in reset.
                if (strap_change) begin
                    count_next = '0;
                end else if (count_reg == 8'(tpbs_pkg::STRAP_SETTLE_CYC - 1)) begin
                    strap_next = strap_sync;
                    count_next = '0;
                    state_next = first_boot_reg ? ST_INIT_BOOT : ST_MCU_BOOT;
                end else begin
                    count_next = count_reg + 8'h01;
                end
            end
            ST_INIT_BOOT: begin
                if (wr_fire && PADDR == tpbs_pkg::CTRL_OFFSET) begin
                    if (PWDATA[tpbs_pkg::CTRL_INIT_DONE_BIT]) begin
                        first_boot_next = 1'b0;
                        master_id_next  = MCU_MASTER_ID;
                        init_done_next  = 1'b1;
                    end
                    if (PWDATA[tpbs_pkg::CTRL_SELF_RST_BIT] && (init_done_reg ||
                        PWDATA[tpbs_pkg::CTRL_INIT_DONE_BIT])) begin
                        count_next = '0;
                        state_next = ST_SELF_RESET;
                    end
                end
                if (wr_fire && PADDR == tpbs_pkg::SECURE_OFFSET) begin
                    secure_next = PWDATA;
                end
            end
            ST_SELF_RESET: begin
                // Flag, identifier and strap are kept across this reset.
                if (count_reg == 8'(tpbs_pkg::SELF_RESET_CYC - 1)) begin
                    count_next = '0;
                    state_next = first_boot_reg ? ST_INIT_BOOT : ST_MCU_BOOT;
                end else begin
                    count_next = count_reg + 8'h01;
                end
            end
            ST_MCU_BOOT: begin
                // Serial load has no timeout and never hands over to the application.
                if (wr_fire && PADDR == tpbs_pkg::CTRL_OFFSET && PWDATA[tpbs_pkg::CTRL_ROM_DONE_BIT] &&
                    mode != tpbs_pkg::MODE_SERIAL_LOAD) begin
                    state_next = ST_APP;
                end
            end
            ST_APP: begin
                state_next = ST_APP;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave.

    always_comb begin
        prdata_next  = '0;
        pready_next  = 1'b0;
        pslverr_next = 1'b0;
        if (PSEL && !PENABLE) begin
            pready_next = 1'b1;
            unique case (PADDR)
                tpbs_pkg::STATUS_OFFSET: begin
                    prdata_next  = status;
                    pslverr_next = PWRITE;
                end
                tpbs_pkg::CTRL_OFFSET: begin
                    prdata_next  = {29'h0000_0000, state_reg == ST_APP, init_done_reg, 1'b0};
                end
                tpbs_pkg::SECURE_OFFSET: begin
                    prdata_next  = secure_ok ? secure_reg : 32'h0000_0000;
                    pslverr_next = !secure_ok;
                end
                default: begin
                    pslverr_next = 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg      <= ST_CAPTURE;
            count_reg      <= '0;
            first_boot_reg <= 1'b1;
            init_done_reg  <= 1'b0;
            master_id_reg  <= INIT_MASTER_ID;
            strap_reg      <= tpbs_pkg::FOUR_WIRE_STRAP_SETTING;
            secure_reg     <= tpbs_pkg::SECURE_RESET;
            prdata_reg     <= '0;
            pready_reg     <= 1'b0;
            pslverr_reg    <= 1'b0;
        end else begin
            state_reg      <= state_next;
            count_reg      <= count_next;
            first_boot_reg <= first_boot_next;
            init_done_reg  <= init_done_next;
            master_id_reg  <= master_id_next;
            strap_reg      <= strap_next;
            secure_reg     <= secure_next;
            prdata_reg     <= prdata_next;
            pready_reg     <= pready_next;
            pslverr_reg    <= pslverr_next;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            CPU_RESETN           <= 1'b0;
            FIRST_BOOT           <= 1'b1;
            DEVICE_INIT_RUN      <= 1'b0;
            APP_JUMP             <= 1'b0;
            SECURE_OPEN          <= 1'b0;
            MASTER_ID            <= INIT_MASTER_ID;
            BOOT_MODE            <= tpbs_pkg::MODE_FOUR_WIRE;
            SERIAL_LOAD_MODE     <= 1'b0;
            FUNC_FOUR_WIRE_DEBUG <= 1'b1;
            FUNC_TWO_WIRE_DEBUG  <= 1'b0;
        end else begin
            CPU_RESETN           <= (state_next != ST_CAPTURE) && (state_next != ST_SELF_RESET);
            FIRST_BOOT           <= first_boot_next;
            DEVICE_INIT_RUN      <= (state_next == ST_INIT_BOOT) && first_boot_next;
            APP_JUMP             <= (state_next == ST_APP);
            SECURE_OPEN          <= (state_next == ST_INIT_BOOT) && first_boot_next;
            MASTER_ID            <= master_id_next;
            BOOT_MODE            <= mode;
            SERIAL_LOAD_MODE     <= (mode == tpbs_pkg::MODE_SERIAL_LOAD);
            FUNC_FOUR_WIRE_DEBUG <= (mode != tpbs_pkg::MODE_TWO_WIRE);
            FUNC_TWO_WIRE_DEBUG  <= (mode == tpbs_pkg::MODE_TWO_WIRE);
        end
    end

    assign PRDATA  = prdata_reg;
    assign PREADY  = pready_reg;
    assign PSLVERR = pslverr_reg;

endmodule

`default_nettype wire

// File: tb/tpbs_sequencer_sva.sv
// Checker of the boot strap sequencer port behaviour.
`timescale 1ns/1ps
`default_nettype none

module tpbs_sequencer_sva #(
    parameter logic [3:0] INIT_MASTER_ID = tpbs_pkg::MASTER_ID_INIT,
    parameter logic [3:0] MCU_MASTER_ID  = tpbs_pkg::MASTER_ID_MCU
) (
    input wire logic        CORE_CLK,
    input wire logic        RESETN,
    input wire logic [2:0]  POWER_UP_STRAP,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        CPU_RESETN,
    input wire logic        FIRST_BOOT,
    input wire logic        DEVICE_INIT_RUN,
    input wire logic        APP_JUMP,
    input wire logic        SECURE_OPEN,
    input wire logic [3:0]  MASTER_ID,
    input wire logic [1:0]  BOOT_MODE,
    input wire logic        SERIAL_LOAD_MODE,
    input wire logic        FUNC_FOUR_WIRE_DEBUG,
    input wire logic        FUNC_TWO_WIRE_DEBUG
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESETN);

    logic acc;
    logic ctrl_wr;
    assign acc     = PSEL && PENABLE && PREADY;
    assign ctrl_wr = acc && PWRITE && (PADDR == tpbs_pkg::CTRL_OFFSET);

    a_por_flag_set: assert property ($rose(RESETN)
        |-> FIRST_BOOT && (MASTER_ID == INIT_MASTER_ID)) else $error("flag not set");
    a_init_entry: assert property ($rose(CPU_RESETN) && FIRST_BOOT
        |-> ##[0:1] (DEVICE_INIT_RUN && SECURE_OPEN)) else $error("no device init");
    a_init_done: assert property (ctrl_wr && PWDATA[0] && DEVICE_INIT_RUN
        |=> !FIRST_BOOT && (MASTER_ID == MCU_MASTER_ID)) else $error("init done");
    a_self_reset: assert property (ctrl_wr && (PWDATA[1:0] == 2'h3) && DEVICE_INIT_RUN
        |=> (!CPU_RESETN && !SECURE_OPEN) [*8] ##[10:14] CPU_RESETN) else $error("self reset");
    a_second_boot: assert property ($rose(CPU_RESETN) && !FIRST_BOOT
        |-> (MASTER_ID == MCU_MASTER_ID) && !DEVICE_INIT_RUN) else $error("second boot");
    a_secure_blocked: assert property (acc && (PADDR == tpbs_pkg::SECURE_OFFSET) && !SECURE_OPEN
        |-> PSLVERR && (PWRITE || (PRDATA == 32'h0))) else $error("secure open");
    a_secure_locked: assert property (!SECURE_OPEN && !FIRST_BOOT |=> !SECURE_OPEN)
        else $error("secure reopened");
    a_app_handover: assert property (ctrl_wr && PWDATA[2] && !FIRST_BOOT && CPU_RESETN && !SERIAL_LOAD_MODE
        |=> APP_JUMP) else $error("no handover");
    a_serial_mode: assert property (CPU_RESETN && SERIAL_LOAD_MODE
        |-> !APP_JUMP && FUNC_FOUR_WIRE_DEBUG && !FUNC_TWO_WIRE_DEBUG) else $error("serial mode");
    a_mode_held: assert property (CPU_RESETN && $past(CPU_RESETN) |=> $stable(BOOT_MODE))
        else $error("mode changed");

    c_app: cover property ($rose(APP_JUMP));
    c_serial: cover property (CPU_RESETN && SERIAL_LOAD_MODE);
    c_refused: cover property (acc && PSLVERR);
endmodule

bind tpbs_sequencer tpbs_sequencer_sva #(.INIT_MASTER_ID(INIT_MASTER_ID), .MCU_MASTER_ID(MCU_MASTER_ID)) u_sva (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .POWER_UP_STRAP(POWER_UP_STRAP), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CPU_RESETN(CPU_RESETN), .FIRST_BOOT(FIRST_BOOT), .DEVICE_INIT_RUN(DEVICE_INIT_RUN), .APP_JUMP(APP_JUMP),
    .SECURE_OPEN(SECURE_OPEN), .MASTER_ID(MASTER_ID), .BOOT_MODE(BOOT_MODE), .SERIAL_LOAD_MODE(SERIAL_LOAD_MODE),
    .FUNC_FOUR_WIRE_DEBUG(FUNC_FOUR_WIRE_DEBUG), .FUNC_TWO_WIRE_DEBUG(FUNC_TWO_WIRE_DEBUG));
`default_nettype wire

// File: tb/tpbs_strap_board.sv
// Board model of the strap pins, with the top pin reused after power-up.
`timescale 1ns/1ps
`default_nettype none

module tpbs_strap_board (
    input  wire logic       clk,
    input  wire logic [2:0] code,
    input  wire logic       reuse,
    output var  logic [2:0] strap
);
    logic toggle_reg = 1'b0;

    // Once reused, the top pin carries a changing output level.
    always @(posedge clk) begin
        toggle_reg <= ~toggle_reg;
    end

    assign strap = {reuse ? toggle_reg : code[2], code[1:0]};
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking testbench of the boot strap sequencer.
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        CORE_CLK   = 1'b0;
    logic        RESETN     = 1'b0;
    logic [2:0]  strap_code = 3'h0;
    logic        pin_reuse  = 1'b0;
    logic        PSEL       = 1'b0;
    logic        PENABLE    = 1'b0;
    logic        PWRITE     = 1'b0;
    logic [11:0] PADDR      = 12'h000;
    logic [31:0] PWDATA     = 32'h0;
    logic [2:0]  strap;
    logic [31:0] PRDATA;
    logic        PREADY, PSLVERR, CPU_RESETN, FIRST_BOOT, DEVICE_INIT_RUN, APP_JUMP, SECURE_OPEN;
    logic        SERIAL_LOAD_MODE, FUNC_FOUR_WIRE_DEBUG, FUNC_TWO_WIRE_DEBUG;
    logic [3:0]  MASTER_ID;
    logic [1:0]  BOOT_MODE;
    logic [31:0] rdata;
    logic        rerr;
    int          n_errors   = 0;
    int          n_compared = 0;

    initial begin
        forever #2.5 CORE_CLK = ~CORE_CLK;
    end

    tpbs_strap_board board (.clk(CORE_CLK), .code(strap_code), .reuse(pin_reuse), .strap(strap));
    tpbs_sequencer dut (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .POWER_UP_STRAP(strap), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .CPU_RESETN(CPU_RESETN), .FIRST_BOOT(FIRST_BOOT), .DEVICE_INIT_RUN(DEVICE_INIT_RUN),
        .APP_JUMP(APP_JUMP), .SECURE_OPEN(SECURE_OPEN), .MASTER_ID(MASTER_ID), .BOOT_MODE(BOOT_MODE),
        .SERIAL_LOAD_MODE(SERIAL_LOAD_MODE), .FUNC_FOUR_WIRE_DEBUG(FUNC_FOUR_WIRE_DEBUG),
        .FUNC_TWO_WIRE_DEBUG(FUNC_TWO_WIRE_DEBUG));

    ////////////////////////////////////////////////////////////////////////////////

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge CORE_CLK);
        PSEL   <= 1'b1;
        PWRITE <= wr;
        PADDR  <= addr;
        PWDATA <= data;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        chk(32'(PREADY), 32'h1, "pready");
        rdata = PRDATA;
        rerr  = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wait_cpu(output int n);
        n = 0;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (CPU_RESETN !== 1'b1 && n < 100);
        chk(32'(CPU_RESETN), 32'h1, "cpu release");
    endtask

    task automatic power_up(input logic [2:0] code);
        int n;
        @(posedge CORE_CLK);
        RESETN     <= 1'b0;
        strap_code <= code;
        pin_reuse  <= 1'b0;
        repeat (8) @(posedge CORE_CLK);
        RESETN <= 1'b1;
        wait_cpu(n);
        @(posedge CORE_CLK);
    endtask

    task automatic sc_decode();
        logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h4, 3'h7};
        logic [1:0] mode;
        foreach (codes[i]) begin
            power_up(codes[i]);
            mode = (codes[i] == tpbs_pkg::FOUR_WIRE_STRAP_SETTING) ? 2'h0 :
                   (codes[i] == tpbs_pkg::TWO_WIRE_STRAP_SETTING) ? 2'h1 :
                   (codes[i] == tpbs_pkg::SERIAL_LOAD_STRAP_SETTING) ? 2'h2 : 2'h3;
            chk(32'(BOOT_MODE), 32'(mode), "mode");
            chk(32'(FUNC_TWO_WIRE_DEBUG), 32'(mode == 2'h1), "two wire");
            chk(32'(FUNC_FOUR_WIRE_DEBUG), 32'(mode != 2'h1), "four wire");
            chk(32'(SERIAL_LOAD_MODE), 32'(mode == 2'h2), "serial");
            apb(1'b0, tpbs_pkg::STATUS_OFFSET, 32'h0);
            chk(32'(rdata[11:9]), 32'(codes[i]), "strap field");
            chk(32'({rdata[15], rdata[0]}), 32'h3, "first boot");
        end
    endtask

    task automatic sc_two_phase(input logic [2:0] code);
        int n;
        power_up(code);
        chk(32'({DEVICE_INIT_RUN, MASTER_ID}), 32'({1'b1, tpbs_pkg::MASTER_ID_INIT}), "init");
        apb(1'b1, tpbs_pkg::SECURE_OFFSET, 32'hA5C3_0F96);
        apb(1'b0, tpbs_pkg::SECURE_OFFSET, 32'h0);
        chk(rdata, 32'hA5C3_0F96, "secure data");
        chk(32'(rerr), 32'h0, "secure ok");
        apb(1'b1, tpbs_pkg::CTRL_OFFSET, 32'h0000_0003);
        @(posedge CORE_CLK);
        chk(32'({FIRST_BOOT, CPU_RESETN}), 32'h0, "flag cleared");
        chk(32'(MASTER_ID), 32'(tpbs_pkg::MASTER_ID_MCU), "mcu id");
        wait_cpu(n);
        chk(32'(n), 32'(tpbs_pkg::SELF_RESET_CYC), "self reset length");
        chk(32'({FIRST_BOOT, DEVICE_INIT_RUN, SECURE_OPEN}), 32'h0, "second boot");
        apb(1'b1, tpbs_pkg::SECURE_OFFSET, 32'hFFFF_FFFF);
        chk(32'(rerr), 32'h1, "secure write");
        apb(1'b0, tpbs_pkg::SECURE_OFFSET, 32'h0);
        chk(rdata, 32'h0, "secure read");
        chk(32'(rerr), 32'h1, "secure err");
        apb(1'b1, tpbs_pkg::CTRL_OFFSET, 32'h0000_0004);
        repeat (40) @(posedge CORE_CLK);
        chk(32'(APP_JUMP), 32'(code != tpbs_pkg::SERIAL_LOAD_STRAP_SETTING), "app");
        chk(32'(SERIAL_LOAD_MODE), 32'(code == tpbs_pkg::SERIAL_LOAD_STRAP_SETTING), "kept");
    endtask

    task automatic sc_refusals();
        int n;
        power_up(tpbs_pkg::FOUR_WIRE_STRAP_SETTING);
        apb(1'b0, tpbs_pkg::SECURE_OFFSET, 32'h0);
        chk(rdata, tpbs_pkg::SECURE_RESET, "secure reset");
        apb(1'b1, 12'h00C, 32'h0000_0001);
        chk(32'(rerr), 32'h1, "unmapped");
        apb(1'b1, tpbs_pkg::STATUS_OFFSET, 32'hFFFF_FFFF);
        chk(32'(rerr), 32'h1, "status write");
        apb(1'b1, tpbs_pkg::CTRL_OFFSET, 32'h0000_0004);
        @(posedge CORE_CLK);
        chk(32'({APP_JUMP, FIRST_BOOT}), 32'h1, "early app");
        pin_reuse  <= 1'b1;
        strap_code <= tpbs_pkg::TWO_WIRE_STRAP_SETTING;
        apb(1'b1, tpbs_pkg::CTRL_OFFSET, 32'h0000_0003);
        wait_cpu(n);
        apb(1'b0, tpbs_pkg::STATUS_OFFSET, 32'h0);
        chk(32'({BOOT_MODE, rdata[11:9]}), 32'h0, "strap held");
    endtask

    task automatic final_report();
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        sc_decode();
        sc_two_phase(tpbs_pkg::FOUR_WIRE_STRAP_SETTING);
        sc_two_phase(tpbs_pkg::SERIAL_LOAD_STRAP_SETTING);
        sc_refusals();
        final_report();
    end

    initial begin
        #250000;
        n_errors++;
        final_report();
    end
endmodule
`default_nettype wire
